// >>> logic/csr3_consts.svh
// Constants for the third stimulus/response stage: addresses, fields, codes, timing.
// Assumes inclusion by bare name from every file that needs them.
`ifndef CSR3_CONSTS_SVH
`define CSR3_CONSTS_SVH

// ****************************************
// Register addresses and reset values
// ****************************************
`define CSR3_ADDR_CFG1 8'h39
`define CSR3_ADDR_CFG2 8'h3A
`define CSR3_ADDR_CFG3 8'h3B
`define CSR3_ADDR_STAT 8'h3C
`define CSR3_CFG1_RST 7'h00
`define CSR3_CFG2_RST 8'h00
`define CSR3_CFG3_RST 6'h00
`define CSR3_RD_IDLE 8'h00

// ****************************************
// Field positions
// ****************************************
`define CSR3_TYPE_BIT 6
`define CSR3_TD_MSB 5
`define CSR3_TD_LSB 3
`define CSR3_SEL_MSB 2
`define CSR3_SEL_LSB 0
`define CSR3_MAG_MSB 7
`define CSR3_MAG_LSB 4
`define CSR3_RSP_MSB 3
`define CSR3_RSP_LSB 0
`define CSR3_PUPD_MSB 5
`define CSR3_PUPD_LSB 4
`define CSR3_TH_MSB 3
`define CSR3_TH_LSB 0

// ****************************************
// Stimulus select codes
// ****************************************
`define CSR3_SEL_VBUS_READY 3'h0
`define CSR3_SEL_DP_ABOVE 3'h1
`define CSR3_SEL_WINDOW 3'h2
`define CSR3_SEL_DM_ABOVE 3'h3
`define CSR3_SEL_RSV_A 3'h4
`define CSR3_SEL_RSV_B 3'h5
`define CSR3_SEL_DP_ABOVE_ALT 3'h6
`define CSR3_SEL_VBUS_PRESENT 3'h7

// ****************************************
// Response, magnitude and threshold codes
// ****************************************
`define CSR3_RSP_REMOVE 4'h0
`define CSR3_RSP_VOLT_DP 4'h1
`define CSR3_RSP_VOLT_DM 4'h2
`define CSR3_RSP_VOLT_BOTH 4'h3
`define CSR3_RSP_RES_DP 4'h4
`define CSR3_RSP_RSV_A 4'h5
`define CSR3_RSP_DIV_DP 4'h6
`define CSR3_RSP_RES_DM 4'h7
`define CSR3_RSP_RSV_B 4'h8
`define CSR3_RSP_DIV_DM 4'h9
`define CSR3_RSP_SHORT 4'hA
`define CSR3_RSP_RSV_C 4'hB
`define CSR3_RSP_DIV_BOTH 4'hC
`define CSR3_RSP_RES_BOTH 4'hD
`define CSR3_RSP_PD_HOLD_A 4'hE
`define CSR3_RSP_PD_HOLD_B 4'hF
`define CSR3_MAG_RSV 4'hF
`define CSR3_MAG_PULLDOWN 4'h0
`define CSR3_TH_RSV 4'hF

// ****************************************
// Timing
// ****************************************
`define CSR3_CLK_KHZ 25000
`define CSR3_TICK_MS 1
`define CSR3_TD0_MS 7'h00
`define CSR3_TD1_MS 7'h01
`define CSR3_TD2_MS 7'h05
`define CSR3_TD3_MS 7'h0A
`define CSR3_TD4_MS 7'h14
`define CSR3_TD5_MS 7'h28
`define CSR3_TD6_MS 7'h50
`define CSR3_TD7_MS 7'h64

`endif

// >>> logic/csr3_pkg.sv
// Types for the third stimulus/response stage.
// Assumes nothing beyond a SystemVerilog compiler.
package csr3_pkg;

	// ****************************************
	// Sequencer states
	// ****************************************
	typedef enum logic [4:0] {
		CSR3_ST_IDLE = 5'h01,
		CSR3_ST_DELAY = 5'h02,
		CSR3_ST_HOLD = 5'h04,
		CSR3_ST_RELEASE = 5'h08,
		CSR3_ST_DONE = 5'h10
	} csr3_state_t;

	// ****************************************
	// Per-line drive kind
	// ****************************************
	typedef enum logic [1:0] {
		CSR3_DRV_NONE = 2'h0,
		CSR3_DRV_VOLT = 2'h1,
		CSR3_DRV_RES = 2'h2,
		CSR3_DRV_DIV = 2'h3
	} csr3_drive_t;

endpackage : csr3_pkg

// >>> logic/csr3_ms_timer.sv
// Millisecond down-counter used for the stimulus delay or hold time.
// Assumes start is a one-cycle pulse from logic on the same clock.
`timescale 1ns/1ps
`include "csr3_consts.svh"

module csr3_ms_timer #(
	parameter logic [15:0] CYC_PER_MS = 16'(`CSR3_CLK_KHZ * `CSR3_TICK_MS)
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [6:0] ms_count,
	output logic done
);

	logic [15:0] pre_q;
	logic [6:0] left_q;
	logic run_q;
	logic done_q;
	wire tick = (pre_q == (CYC_PER_MS - 16'h0001));
	wire expire = run_q && (left_q == 7'h00);

	// Restart on every start pulse, even mid-count
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pre_q <= 16'h0000;
			left_q <= 7'h00;
			run_q <= 1'b0;
			done_q <= 1'b0;
		end
		else if (start)
		begin
			pre_q <= 16'h0000;
			left_q <= ms_count;
			run_q <= 1'b1;
			done_q <= 1'b0;
		end
		else
		begin
			done_q <= expire;
			if (expire)
				run_q <= 1'b0;
			else if (run_q && tick)
			begin
				pre_q <= 16'h0000;
				left_q <= left_q - 7'h01;
			end
			else if (run_q)
				pre_q <= pre_q + 16'h0001;
		end
	end

	assign done = done_q;

endmodule : csr3_ms_timer

// >>> logic/csr3_stage.sv
// Third stimulus/response stage of the charger emulation engine: config registers,
// stimulus detection, delay or hold timing, and the data-line response drive.
// Assumes analog comparators report on pins and the engine sequences stages.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`include "csr3_consts.svh"

module csr3_stage #(
	parameter logic [15:0] CYC_PER_MS = 16'(`CSR3_CLK_KHZ * `CSR3_TICK_MS)
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic stage_active,
	input wire logic emul_reset,
	input wire logic vbus_ready,
	input wire logic vbus_present,
	input wire logic dp_above_th,
	input wire logic dm_above_th,
	input wire logic dp_above_low,
	output logic [1:0] dp_drive,
	output logic [1:0] dm_drive,
	output logic [3:0] response_magnitude_code,
	output logic line_short,
	output logic dp_reset_pulldown,
	output logic dm_reset_pulldown,
	output logic pulldown_current_en,
	output logic [1:0] pulldown_current_code,
	output logic [3:0] data_line_threshold_code,
	output logic threshold_used,
	output logic stage_done
);

	// ****************************************
	// Registers and bus
	// ****************************************
	logic [6:0] cfg1_q;
	logic [7:0] cfg2_q;
	logic [5:0] cfg3_q;
	logic [7:0] rdata_q;
	csr3_pkg::csr3_state_t state_q;
	csr3_pkg::csr3_state_t state_d;
	logic stim_hit;

	wire timer_behaviour_select = cfg1_q[`CSR3_TYPE_BIT];
	wire [2:0] stimulus_delay_code = cfg1_q[`CSR3_TD_MSB:`CSR3_TD_LSB];
	wire [2:0] stimulus_select = cfg1_q[`CSR3_SEL_MSB:`CSR3_SEL_LSB];
	wire [3:0] mag_field = cfg2_q[`CSR3_MAG_MSB:`CSR3_MAG_LSB];
	wire [3:0] response_select = cfg2_q[`CSR3_RSP_MSB:`CSR3_RSP_LSB];

	wire wr_cfg1 = wr && (addr == `CSR3_ADDR_CFG1);
	wire wr_cfg2 = wr && (addr == `CSR3_ADDR_CFG2);
	wire wr_cfg3 = wr && (addr == `CSR3_ADDR_CFG3);
	wire [3:0] w_mag = wdata[`CSR3_MAG_MSB:`CSR3_MAG_LSB];
	wire [3:0] w_rsp = wdata[`CSR3_RSP_MSB:`CSR3_RSP_LSB];
	wire [3:0] w_th = wdata[`CSR3_TH_MSB:`CSR3_TH_LSB];
	wire mag_ok = (w_mag != `CSR3_MAG_RSV);
	wire rsp_ok = (w_rsp != `CSR3_RSP_RSV_A) && (w_rsp != `CSR3_RSP_RSV_B)
		&& (w_rsp != `CSR3_RSP_RSV_C);
	wire th_ok = (w_th != `CSR3_TH_RSV);

	wire [7:0] stat_word = {1'b0, stage_done, stim_hit, state_q};
	wire [7:0] rd_mux = (addr == `CSR3_ADDR_CFG1) ? {1'b0, cfg1_q} :
		(addr == `CSR3_ADDR_CFG2) ? cfg2_q :
		(addr == `CSR3_ADDR_CFG3) ? {2'h0, cfg3_q} :
		(addr == `CSR3_ADDR_STAT) ? stat_word : `CSR3_RD_IDLE;

	// Config changes act at once; software should write only while the stage is idle
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cfg1_q <= `CSR3_CFG1_RST;
			cfg2_q <= `CSR3_CFG2_RST;
			cfg3_q <= `CSR3_CFG3_RST;
		end
		else
		begin
			if (wr_cfg1)
				cfg1_q <= wdata[6:0];
			if (wr_cfg2 && mag_ok)
				cfg2_q[`CSR3_MAG_MSB:`CSR3_MAG_LSB] <= w_mag;
			if (wr_cfg2 && rsp_ok)
				cfg2_q[`CSR3_RSP_MSB:`CSR3_RSP_LSB] <= w_rsp;
			if (wr_cfg3)
				cfg3_q[`CSR3_PUPD_MSB:`CSR3_PUPD_LSB] <= wdata[`CSR3_PUPD_MSB:`CSR3_PUPD_LSB];
			if (wr_cfg3 && th_ok)
				cfg3_q[`CSR3_TH_MSB:`CSR3_TH_LSB] <= w_th;
		end
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			rdata_q <= `CSR3_RD_IDLE;
		else
			rdata_q <= rd ? rd_mux : `CSR3_RD_IDLE;
	end

	// ****************************************
	// Comparator synchronisers
	// ****************************************
	logic [4:0] pin_meta_q;
	logic [4:0] pin_sync_q;

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_meta_q <= 5'h00;
			pin_sync_q <= 5'h00;
		end
		else
		begin
			pin_meta_q <= {vbus_ready, vbus_present, dp_above_th, dm_above_th, dp_above_low};
			pin_sync_q <= pin_meta_q;
		end
	end

	wire s_vbus_ready = pin_sync_q[4];
	wire s_vbus_present = pin_sync_q[3];
	wire s_dp_hi = pin_sync_q[2];
	wire s_dm_hi = pin_sync_q[1];
	wire s_dp_low = pin_sync_q[0];

	// ****************************************
	// Stimulus detection
	// ****************************************
	wire sel_vbus = (stimulus_select == `CSR3_SEL_VBUS_READY)
		|| (stimulus_select == `CSR3_SEL_VBUS_PRESENT);
	wire hit_ready = (stimulus_select == `CSR3_SEL_VBUS_READY) && s_vbus_ready;
	wire hit_dp = ((stimulus_select == `CSR3_SEL_DP_ABOVE)
		|| (stimulus_select == `CSR3_SEL_DP_ABOVE_ALT)) && s_dp_hi;
	wire hit_dm = (stimulus_select == `CSR3_SEL_DM_ABOVE) && s_dm_hi;
	// Window only watches the positive line; there is no negative-line lower comparator
	wire hit_win = (stimulus_select == `CSR3_SEL_WINDOW) && !s_dp_hi && s_dp_low;
	wire hit_present = (stimulus_select == `CSR3_SEL_VBUS_PRESENT) && s_vbus_present;
	assign stim_hit = hit_ready || hit_dp || hit_dm || hit_win || hit_present;

	// ****************************************
	// Timer
	// ****************************************
	logic [6:0] delay_ms;
	logic tmr_done;
	wire detect = (state_q == csr3_pkg::CSR3_ST_IDLE) && stage_active && stim_hit && !emul_reset;

	always_comb
	begin
		unique case (stimulus_delay_code)
			3'h0: delay_ms = `CSR3_TD0_MS;
			3'h1: delay_ms = `CSR3_TD1_MS;
			3'h2: delay_ms = `CSR3_TD2_MS;
			3'h3: delay_ms = `CSR3_TD3_MS;
			3'h4: delay_ms = `CSR3_TD4_MS;
			3'h5: delay_ms = `CSR3_TD5_MS;
			3'h6: delay_ms = `CSR3_TD6_MS;
			3'h7: delay_ms = `CSR3_TD7_MS;
		endcase
	end

	csr3_ms_timer #(
		.CYC_PER_MS(CYC_PER_MS)
	) u_timer (
		.clock(clock),
		.rst_n(rst_n),
		.start(detect),
		.ms_count(delay_ms),
		.done(tmr_done)
	);

	// ****************************************
	// Sequencer
	// ****************************************
	wire do_apply = (detect && timer_behaviour_select)
		|| ((state_q == csr3_pkg::CSR3_ST_DELAY) && tmr_done);
	wire do_restore = (state_q == csr3_pkg::CSR3_ST_HOLD) && tmr_done && !stim_hit;

	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			csr3_pkg::CSR3_ST_IDLE:
				if (detect)
					state_d = timer_behaviour_select ? csr3_pkg::CSR3_ST_HOLD
						: csr3_pkg::CSR3_ST_DELAY;
			csr3_pkg::CSR3_ST_DELAY:
				if (tmr_done)
					state_d = csr3_pkg::CSR3_ST_RELEASE;
			csr3_pkg::CSR3_ST_HOLD:
				if (tmr_done)
					state_d = csr3_pkg::CSR3_ST_RELEASE;
			csr3_pkg::CSR3_ST_RELEASE:
				if (sel_vbus || !stim_hit)
					state_d = csr3_pkg::CSR3_ST_DONE;
			csr3_pkg::CSR3_ST_DONE:
				state_d = csr3_pkg::CSR3_ST_DONE;
		endcase
		if (!stage_active || emul_reset)
			state_d = csr3_pkg::CSR3_ST_IDLE;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			state_q <= csr3_pkg::CSR3_ST_IDLE;
		else
			state_q <= state_d;
	end

	// ****************************************
	// Response decode
	// ****************************************
	logic [1:0] dp_q, dm_q, snap_dp_q, snap_dm_q;
	logic [3:0] mag_q, snap_mag_q;
	logic short_q, dp_pd_q, dm_pd_q, snap_short_q, snap_dp_pd_q, snap_dm_pd_q;
	logic [1:0] ap_dp, ap_dm;
	logic ap_short, ap_dp_pd, ap_dm_pd;

	// A one-line drive keeps its pull-down only under ready-stimulus with nothing else on that line
	wire keep_dp = (stimulus_select == `CSR3_SEL_VBUS_READY)
		&& (dp_q == csr3_pkg::CSR3_DRV_NONE) && dp_pd_q;
	wire keep_dm = (stimulus_select == `CSR3_SEL_VBUS_READY)
		&& (dm_q == csr3_pkg::CSR3_DRV_NONE) && dm_pd_q;

	always_comb
	begin
		ap_dp = dp_q;
		ap_dm = dm_q;
		ap_short = short_q;
		ap_dp_pd = dp_pd_q;
		ap_dm_pd = dm_pd_q;
		unique case (response_select)
			`CSR3_RSP_REMOVE:
			begin
				ap_dp = csr3_pkg::CSR3_DRV_NONE;
				ap_dm = csr3_pkg::CSR3_DRV_NONE;
				ap_short = 1'b0;
				ap_dp_pd = 1'b0;
				ap_dm_pd = 1'b0;
			end
			`CSR3_RSP_VOLT_DP:
			begin
				ap_dp = csr3_pkg::CSR3_DRV_VOLT;
				ap_dp_pd = keep_dp;
			end
			`CSR3_RSP_VOLT_DM:
			begin
				ap_dm = csr3_pkg::CSR3_DRV_VOLT;
				ap_dm_pd = keep_dm;
			end
			`CSR3_RSP_VOLT_BOTH:
			begin
				ap_dp = csr3_pkg::CSR3_DRV_VOLT;
				ap_dm = csr3_pkg::CSR3_DRV_VOLT;
				ap_dp_pd = 1'b0;
				ap_dm_pd = 1'b0;
			end
			`CSR3_RSP_RES_DP:
			begin
				ap_dp = csr3_pkg::CSR3_DRV_RES;
				ap_dp_pd = keep_dp;
			end
			`CSR3_RSP_RES_DM:
			begin
				ap_dm = csr3_pkg::CSR3_DRV_RES;
				ap_dm_pd = keep_dm;
			end
			`CSR3_RSP_RES_BOTH:
			begin
				ap_dp = csr3_pkg::CSR3_DRV_RES;
				ap_dm = csr3_pkg::CSR3_DRV_RES;
				ap_dp_pd = 1'b0;
				ap_dm_pd = 1'b0;
			end
			`CSR3_RSP_DIV_DP:
			begin
				ap_dp = csr3_pkg::CSR3_DRV_DIV;
				ap_dp_pd = keep_dp;
			end
			`CSR3_RSP_DIV_DM:
			begin
				ap_dm = csr3_pkg::CSR3_DRV_DIV;
				ap_dm_pd = keep_dm;
			end
			`CSR3_RSP_DIV_BOTH:
			begin
				ap_dp = csr3_pkg::CSR3_DRV_DIV;
				ap_dm = csr3_pkg::CSR3_DRV_DIV;
				ap_dp_pd = 1'b0;
				ap_dm_pd = 1'b0;
			end
			`CSR3_RSP_SHORT:
				ap_short = 1'b1;
			`CSR3_RSP_PD_HOLD_A, `CSR3_RSP_PD_HOLD_B:
				if (stimulus_select == `CSR3_SEL_VBUS_PRESENT)
				begin
					ap_dp_pd = 1'b0;
					ap_dm_pd = 1'b0;
				end
			// Reserved codes never reach the register; nothing to apply
			`CSR3_RSP_RSV_A, `CSR3_RSP_RSV_B, `CSR3_RSP_RSV_C:
			begin
			end
		endcase
	end

	// ****************************************
	// Drive state
	// ****************************************
	wire [1:0] nx_dp = emul_reset ? csr3_pkg::CSR3_DRV_NONE : do_restore ? snap_dp_q : ap_dp;
	wire [1:0] nx_dm = emul_reset ? csr3_pkg::CSR3_DRV_NONE : do_restore ? snap_dm_q : ap_dm;
	wire [3:0] nx_mag = emul_reset ? `CSR3_MAG_PULLDOWN : do_restore ? snap_mag_q : mag_field;
	wire nx_short = emul_reset ? 1'b0 : do_restore ? snap_short_q : ap_short;
	wire nx_dp_pd = emul_reset ? 1'b1 : do_restore ? snap_dp_pd_q : ap_dp_pd;
	wire nx_dm_pd = emul_reset ? 1'b1 : do_restore ? snap_dm_pd_q : ap_dm_pd;
	wire load = emul_reset || do_restore || do_apply;
	wire nx_isink = ((nx_dp == csr3_pkg::CSR3_DRV_VOLT) || (nx_dm == csr3_pkg::CSR3_DRV_VOLT))
		&& (nx_mag == `CSR3_MAG_PULLDOWN);
	logic isink_q;
	logic th_used_q;
	logic done_q;

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			{dp_q, dm_q, mag_q, short_q, dp_pd_q, dm_pd_q, isink_q} <= 12'h000;
		end
		else if (load)
		begin
			{dp_q, dm_q, mag_q, short_q, dp_pd_q, dm_pd_q, isink_q} <=
				{nx_dp, nx_dm, nx_mag, nx_short, nx_dp_pd, nx_dm_pd, nx_isink};
		end
	end

	// Snapshot before a held response, so expiry can put the lines back
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			{snap_dp_q, snap_dm_q, snap_mag_q, snap_short_q, snap_dp_pd_q, snap_dm_pd_q} <= 11'h000;
		else if (detect && timer_behaviour_select)
			{snap_dp_q, snap_dm_q, snap_mag_q, snap_short_q, snap_dp_pd_q, snap_dm_pd_q} <=
				{dp_q, dm_q, mag_q, short_q, dp_pd_q, dm_pd_q};
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			th_used_q <= 1'b0;
			done_q <= 1'b0;
		end
		else
		begin
			th_used_q <= !sel_vbus;
			done_q <= (state_d == csr3_pkg::CSR3_ST_DONE);
		end
	end

	assign rdata = rdata_q;
	assign dp_drive = dp_q;
	assign dm_drive = dm_q;
	assign response_magnitude_code = mag_q;
	assign line_short = short_q;
	assign dp_reset_pulldown = dp_pd_q;
	assign dm_reset_pulldown = dm_pd_q;
	assign pulldown_current_en = isink_q;
	assign pulldown_current_code = cfg3_q[`CSR3_PUPD_MSB:`CSR3_PUPD_LSB];
	assign data_line_threshold_code = cfg3_q[`CSR3_TH_MSB:`CSR3_TH_LSB];
	assign threshold_used = th_used_q;
	assign stage_done = done_q;

endmodule : csr3_stage

// >>> verification/csr3_properties.sv
// Concurrent checks on the third stimulus/response stage, seen at its ports only.
// Assumes a bind from the bench top file onto the stage.
`timescale 1ns/1ps

module csr3_properties (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic stage_active,
	input wire logic emul_reset,
	input wire logic [1:0] dp_drive,
	input wire logic [1:0] dm_drive,
	input wire logic [3:0] response_magnitude_code,
	input wire logic line_short,
	input wire logic dp_reset_pulldown,
	input wire logic dm_reset_pulldown,
	input wire logic pulldown_current_en,
	input wire logic [1:0] pulldown_current_code,
	input wire logic [3:0] data_line_threshold_code,
	input wire logic threshold_used,
	input wire logic stage_done
);
	// ****************************************
	// Helpers and sequences
	// ****************************************
	wire logic [2:0] wsel = wdata[2:0];
	wire logic [1:0] wpu = wdata[5:4];

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	// A second select write right behind would change the expected value
	sequence s_cfg1_write;
		wr && addr == 8'h39 ##1 !(wr && addr == 8'h39);
	endsequence

	sequence s_stable_done;
		stage_done && stage_active && $past(stage_active) && !emul_reset && !$past(emul_reset);
	endsequence

	// ****************************************
	// Assertions
	// ****************************************
	AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("read data not idle outside a read reply");
	AST_RD_CFG3: assert property (rd && addr == 8'h3B |=>
		rdata == {2'h0, pulldown_current_code, data_line_threshold_code})
		else $error("configuration three read back wrong");
	AST_TH_REJECT: assert property (wr && addr == 8'h3B && wdata[3:0] == 4'hF |=>
		$stable(data_line_threshold_code) && pulldown_current_code == $past(wpu))
		else $error("reserved threshold accepted or current code lost");
	AST_TH_USED: assert property (s_cfg1_write |-> ##1
		threshold_used == ($past(wsel, 2) != 3'h0 && $past(wsel, 2) != 3'h7))
		else $error("threshold use does not follow select");
	AST_EMUL_RESET: assert property (emul_reset |=> dp_reset_pulldown && dm_reset_pulldown
		&& dp_drive == 2'h0 && dm_drive == 2'h0 && !line_short)
		else $error("emulation reset did not clear drives");
	AST_PD_CURRENT: assert property (pulldown_current_en |->
		response_magnitude_code == 4'h0 && (dp_drive == 2'h1 || dm_drive == 2'h1))
		else $error("pull-down current without voltage response at zero");
	AST_DRIVE_CAUSE: assert property (
		($changed(dp_drive) || $changed(dm_drive) || $changed(line_short))
		|-> $past(stage_active) || $past(emul_reset))
		else $error("drive changed with stage idle");
	AST_DONE_HOLD: assert property (s_stable_done |=> stage_done)
		else $error("done dropped while stage active");
	AST_DONE_CAUSE: assert property ($rose(stage_done) |-> $past(stage_active))
		else $error("done rose without stage active");
endmodule : csr3_properties

// >>> verification/csr3_device_model.sv
// Portable device model: presents comparator conditions on the port lines.
// Assumes the bench picks the condition kind and when it is present.
`timescale 1ns/1ps

module csr3_device_model (
	input wire logic clock,
	input wire logic on,
	input wire logic [2:0] kind,
	output logic vbus_ready,
	output logic vbus_present,
	output logic dp_above_th,
	output logic dm_above_th,
	output logic dp_above_low
);
	initial
	begin
		{vbus_ready, vbus_present, dp_above_th, dm_above_th, dp_above_low} = 5'h00;
	end

	// A high positive line is above both the threshold and the fixed lower level
	always @(posedge clock)
	begin
		vbus_ready <= on && kind == 3'h0;
		vbus_present <= on && kind == 3'h7;
		dp_above_th <= on && kind == 3'h1;
		dp_above_low <= on && (kind == 3'h1 || kind == 3'h2);
		dm_above_th <= on && kind == 3'h3;
	end
endmodule : csr3_device_model

// >>> verification/tb_top.sv
// Bench for the third stimulus/response stage with a device model on the comparator pins.
// Assumes the stage, the checker and the device model are compiled first.
`timescale 1ns/1ps

module tb_top;
	logic clock = 1'h0;
	logic rst_n = 1'h0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'h0;
	logic rd = 1'h0;
	logic stage_active = 1'h0;
	logic emul_reset = 1'h0;
	logic stim_on = 1'h0;
	logic [2:0] stim_kind = 3'h0;
	logic vbus_ready, vbus_present, dp_above_th, dm_above_th, dp_above_low;
	logic [7:0] rdata;
	logic [1:0] dp_drive, dm_drive, pulldown_current_code;
	logic [3:0] response_magnitude_code, data_line_threshold_code;
	logic line_short, dp_reset_pulldown, dm_reset_pulldown, pulldown_current_en;
	logic threshold_used, stage_done;
	int err_count = 0;
	int n_compared = 0;
	int cycles = 0;

	always #20 clock = ~clock;

	// Short millisecond keeps the 100 ms code affordable
	csr3_stage #(.CYC_PER_MS(16'h0004)) i_dut (.clock(clock), .rst_n(rst_n), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .stage_active(stage_active),
		.emul_reset(emul_reset), .vbus_ready(vbus_ready), .vbus_present(vbus_present),
		.dp_above_th(dp_above_th), .dm_above_th(dm_above_th), .dp_above_low(dp_above_low),
		.dp_drive(dp_drive), .dm_drive(dm_drive),
		.response_magnitude_code(response_magnitude_code), .line_short(line_short),
		.dp_reset_pulldown(dp_reset_pulldown), .dm_reset_pulldown(dm_reset_pulldown),
		.pulldown_current_en(pulldown_current_en), .pulldown_current_code(pulldown_current_code),
		.data_line_threshold_code(data_line_threshold_code), .threshold_used(threshold_used),
		.stage_done(stage_done));

	csr3_device_model i_dev (.clock(clock), .on(stim_on), .kind(stim_kind),
		.vbus_ready(vbus_ready), .vbus_present(vbus_present), .dp_above_th(dp_above_th),
		.dm_above_th(dm_above_th), .dp_above_low(dp_above_low));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			$display("ERROR %s expected %h seen %h", what, exp, seen);
			err_count++;
		end
	endtask : check

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge clock);
		wr <= 1'h0;
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		addr <= a;
		rd <= 1'h1;
		@(posedge clock);
		rd <= 1'h0;
		@(posedge clock);
		d = rdata;
	endtask : rd_reg

	task automatic idle;
		@(posedge clock);
		stage_active <= 1'h0;
		stim_on <= 1'h0;
		repeat (4) @(posedge clock);
	endtask : idle

	// Stimulus is taken away once a drive shows, so waiting selects can finish
	task automatic run(input logic [7:0] c1, input logic [7:0] c2, input logic [2:0] kind,
		output int n, output int na);
		wr_reg(8'h39, c1);
		wr_reg(8'h3A, c2);
		@(posedge clock);
		emul_reset <= 1'h1;
		@(posedge clock);
		emul_reset <= 1'h0;
		stim_kind <= kind;
		stim_on <= 1'h1;
		stage_active <= 1'h1;
		n = 0;
		na = -1;
		while (stage_done !== 1'h1 && n < 600)
		begin
			@(posedge clock);
			n++;
			if (na < 0 && (dp_drive !== 2'h0 || dm_drive !== 2'h0 || line_short !== 1'h0))
				na = n;
			if (na == n || n == 450)
				stim_on <= 1'h0;
		end
	endtask : run

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic hit_case(input logic [7:0] c1, input logic [7:0] c2, input logic [2:0] kind,
		input logic [1:0] edp, input logic [1:0] edm, input logic es, input logic [1:0] epd);
		int n;
		int na;
		run(c1, c2, kind, n, na);
		check("done", stage_done, 1'h1);
		check("positive drive", dp_drive, edp);
		check("negative drive", dm_drive, edm);
		check("short", line_short, es);
		check("pulldowns", {dp_reset_pulldown, dm_reset_pulldown}, epd);
		check("magnitude", response_magnitude_code, c2[7:4]);
		check("current", pulldown_current_en, (edp == 2'h1 || edm == 2'h1) && c2[7:4] == 4'h0);
		idle();
		$display("test response %h %h done", c1, c2);
	endtask : hit_case

	task automatic miss_case(input logic [7:0] c1, input logic [2:0] kind);
		int n;
		int na;
		run(c1, 8'h51, kind, n, na);
		check("no detection", stage_done, 1'h0);
		check("no drive", dp_drive, 2'h0);
		idle();
		$display("test no detection %h done", c1);
	endtask : miss_case

	task automatic t_regs;
		logic [7:0] d;
		logic [7:0] w[4] = '{8'h35, 8'h48, 8'h5B, 8'hF2};
		logic [7:0] e[4] = '{8'h31, 8'h41, 8'h51, 8'h52};
		logic [7:0] a[4] = '{8'h39, 8'h3A, 8'h3B, 8'h50};
		for (int i = 0; i < 4; i++)
		begin
			rd_reg(a[i], d);
			check("reset value", d, 8'h00);
		end
		wr_reg(8'h3A, 8'h21);
		for (int i = 0; i < 4; i++)
		begin
			wr_reg(8'h3A, w[i]);
			rd_reg(8'h3A, d);
			check("reserved write", d, e[i]);
		end
		wr_reg(8'h39, 8'hFF);
		rd_reg(8'h39, d);
		check("select register", d, 8'h7F);
		wr_reg(8'h3B, 8'h2F);
		@(posedge clock);
		check("current code", pulldown_current_code, 2'h2);
		check("threshold kept", data_line_threshold_code, 4'h0);
		wr_reg(8'h3B, 8'h15);
		rd_reg(8'h3B, d);
		check("threshold taken", d, 8'h15);
		for (int i = 0; i < 8; i++)
		begin
			wr_reg(8'h39, 8'(i));
			repeat (2) @(posedge clock);
			if (i != 4 && i != 5)
				check("threshold used", threshold_used, i != 0 && i != 7);
		end
		$display("test registers done");
	endtask : t_regs

	task automatic t_timing;
		int ms[8] = '{0, 1, 5, 10, 20, 40, 80, 100};
		int n;
		int na;
		for (int i = 0; i < 8; i++)
		begin
			run({2'h0, 3'(i), 3'h0}, 8'h51, 3'h0, n, na);
			check("delay low", na >= ms[i] * 4 + 2, 1'h1);
			check("delay high", na <= ms[i] * 4 + 12, 1'h1);
			idle();
		end
		run(8'h51, 8'h34, 3'h1, n, na);
		check("hold applied at once", na <= 10, 1'h1);
		check("hold length", n >= 20, 1'h1);
		check("restored", dp_drive, 2'h0);
		idle();
		$display("test timing done");
	endtask : t_timing

	// ****************************************
	// Main sequence and hang guard
	// ****************************************
	initial
	begin
		repeat (2) @(posedge clock);
		rst_n <= 1'h1;
		t_regs();
		t_timing();
		hit_case(8'h00, 8'h02, 3'h0, 2'h0, 2'h1, 1'h0, 2'h3);
		hit_case(8'h00, 8'hE3, 3'h0, 2'h1, 2'h1, 1'h0, 2'h0);
		hit_case(8'h00, 8'h04, 3'h0, 2'h2, 2'h0, 1'h0, 2'h3);
		hit_case(8'h00, 8'h76, 3'h0, 2'h3, 2'h0, 1'h0, 2'h3);
		hit_case(8'h00, 8'hE7, 3'h0, 2'h0, 2'h2, 1'h0, 2'h3);
		hit_case(8'h00, 8'h49, 3'h0, 2'h0, 2'h3, 1'h0, 2'h3);
		hit_case(8'h00, 8'h0A, 3'h0, 2'h0, 2'h0, 1'h1, 2'h3);
		hit_case(8'h00, 8'h8C, 3'h0, 2'h3, 2'h3, 1'h0, 2'h0);
		hit_case(8'h00, 8'h3D, 3'h0, 2'h2, 2'h2, 1'h0, 2'h0);
		hit_case(8'h00, 8'h0E, 3'h0, 2'h0, 2'h0, 1'h0, 2'h3);
		hit_case(8'h07, 8'h3F, 3'h7, 2'h0, 2'h0, 1'h0, 2'h0);
		hit_case(8'h07, 8'h51, 3'h7, 2'h1, 2'h0, 1'h0, 2'h1);
		hit_case(8'h01, 8'h0E, 3'h1, 2'h0, 2'h0, 1'h0, 2'h3);
		hit_case(8'h02, 8'h51, 3'h2, 2'h1, 2'h0, 1'h0, 2'h1);
		hit_case(8'h06, 8'h51, 3'h1, 2'h1, 2'h0, 1'h0, 2'h1);
		hit_case(8'h03, 8'h52, 3'h3, 2'h0, 2'h1, 1'h0, 2'h2);
		miss_case(8'h02, 3'h1);
		miss_case(8'h03, 3'h1);
		miss_case(8'h01, 3'h2);
		summarize();
	end

	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			err_count++;
			summarize();
		end
	end
endmodule : tb_top

bind csr3_stage csr3_properties i_chk (.clock(clock), .rst_n(rst_n), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .stage_active(stage_active),
	.emul_reset(emul_reset), .dp_drive(dp_drive), .dm_drive(dm_drive),
	.response_magnitude_code(response_magnitude_code), .line_short(line_short),
	.dp_reset_pulldown(dp_reset_pulldown), .dm_reset_pulldown(dm_reset_pulldown),
	.pulldown_current_en(pulldown_current_en), .pulldown_current_code(pulldown_current_code),
	.data_line_threshold_code(data_line_threshold_code), .threshold_used(threshold_used),
	.stage_done(stage_done));
